// ==== design/pprf_page_mem.v ====
/*
 Small paged store: eight pages of eight 8-bit registers, read data registered.
 Assumes one synchronous write port and one read port on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none

module pprf_page_mem #(
   parameter AW = 6,
   parameter DW = 8
) (
   input wire clk,
   input wire rst_n,
   input wire wr_en,
   input wire [AW-1:0] wr_addr,
   input wire [DW-1:0] wr_data,
   input wire [AW-1:0] rd_addr,
   output reg [DW-1:0] rd_data
);

   reg [DW-1:0] mem_r [0:(1<<AW)-1];
   integer i;

   // ---------------------------------------------------------------
   // Storage; cleared at reset so unwritten pages read as zero
   // ---------------------------------------------------------------
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (i = 0; i < (1<<AW); i = i + 1) begin
            mem_r[i] <= {DW{1'b0}};
         end
      end else if (wr_en) begin
         mem_r[wr_addr] <= wr_data;
      end
   end

   // Registered read, one cycle latency
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data <= {DW{1'b0}};
      end else begin
         rd_data <= mem_r[rd_addr];
      end
   end

endmodule

`default_nettype wire

// ==== design/pprf_regfile.v ====
/*
 Paged register file of a one-port serial-bus cable PHY, reached over AXI4-Lite.
 Assumes the PHY core drives node status inputs asynchronously to sys_clk and sees bus resets as pulses.
*/
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "pprf_defs.vh"

module pprf_regfile (
   input wire sys_clk,
   input wire rst_n,
   // AXI4-Lite slave
   input wire [31:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [31:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // PHY core side
   input wire [5:0] node_number,
   input wire root_flag,
   input wire cable_power_state,
   input wire bus_reset_pulse,
   input wire gap_cfg_valid,
   input wire [5:0] gap_cfg_value,
   output reg root_holdoff,
   output reg force_long_reset,
   output reg [5:0] gap_count,
   output reg link_active_control,
   output reg [7:0] event_enables,
   output reg [2:0] page_select,
   output reg [3:0] port_select
);

   // ---------------------------------------------------------------
   // Reset synchroniser
   // ---------------------------------------------------------------
   reg rst_meta_r;
   reg rst_sync_r;
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_r <= 1'b0;
         rst_sync_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_sync_r <= rst_meta_r;
      end
   end

   // Status inputs cross from the analog core, so two flops each
   reg [7:0] stat_meta_r;
   reg [7:0] stat_r;
   always @(posedge sys_clk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         stat_meta_r <= 8'h00;
         stat_r <= 8'h00;
      end else begin
         stat_meta_r <= {node_number, root_flag, cable_power_state};
         stat_r <= stat_meta_r;
      end
   end

   // Converts a field laid out MSB-first (position 0 = bit 7) into a byte
   function [7:0] pos_byte;
      input [7:0] fields;
      begin
         pos_byte = fields;
      end
   endfunction

   // ---------------------------------------------------------------
   // AXI write channel: address and data taken in either order
   // ---------------------------------------------------------------
   reg aw_held_r;
   reg w_held_r;
   reg [3:0] aw_idx_r;
   reg aw_out_r;
   reg [7:0] wdata_r;
   reg wlane_r;
   wire aw_take = s_axi_awvalid && s_axi_awready;
   wire w_take = s_axi_wvalid && s_axi_wready;
   // Readies stay low until the synchronised reset lets go, so nothing is taken and lost
   assign s_axi_awready = !aw_held_r && !s_axi_bvalid && rst_sync_r;
   assign s_axi_wready = !w_held_r && !s_axi_bvalid && rst_sync_r;
   wire have_aw = aw_held_r || aw_take;
   wire have_w = w_held_r || w_take;
   wire [3:0] cur_widx = aw_held_r ? aw_idx_r : s_axi_awaddr[5:2];
   wire cur_wout = aw_held_r ? aw_out_r : (s_axi_awaddr[31:6] != 26'h0);
   wire [7:0] cur_wdata = w_held_r ? wdata_r : s_axi_wdata[7:0];
   wire cur_wlane = w_held_r ? wlane_r : s_axi_wstrb[0];
   wire do_write = have_aw && have_w && !s_axi_bvalid;
   wire reg_we = do_write && !cur_wout && cur_wlane;

   always @(posedge sys_clk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         aw_idx_r <= 4'h0;
         aw_out_r <= 1'b0;
         wdata_r <= 8'h00;
         wlane_r <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `PPRF_RESP_OKAY;
      end else begin
         if (do_write) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= cur_wout ? `PPRF_RESP_SLVERR : `PPRF_RESP_OKAY;
         end else begin
            if (aw_take) begin
               aw_held_r <= 1'b1;
               aw_idx_r <= s_axi_awaddr[5:2];
               aw_out_r <= (s_axi_awaddr[31:6] != 26'h0);
            end
            if (w_take) begin
               w_held_r <= 1'b1;
               wdata_r <= s_axi_wdata[7:0];
               wlane_r <= s_axi_wstrb[0];
            end
            if (s_axi_bvalid && s_axi_bready) begin
               s_axi_bvalid <= 1'b0;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Base registers; bit 7 of a byte is position 0
   // ---------------------------------------------------------------
   reg bus_reset_seen_r;
   reg [2:0] pwr_class_r;
   reg contender_r;
   wire paged_slot = cur_widx[3];
   wire page_writable = (page_select < `PPRF_PAGE_RSVD_LO) ||
                        (page_select > `PPRF_PAGE_RSVD_HI);
   wire gap_written = (reg_we && cur_widx == `PPRF_IDX_RESET_GAP) || gap_cfg_valid;

   always @(posedge sys_clk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         root_holdoff <= 1'b0;
         force_long_reset <= 1'b0;
         gap_count <= `PPRF_GAP_RESET;
         link_active_control <= `PPRF_LINK_ACTIVE_CONTROL_RESET;
         contender_r <= 1'b0;
         pwr_class_r <= 3'h0;
         event_enables <= 8'h00;
         page_select <= 3'h0;
         port_select <= 4'h0;
         bus_reset_seen_r <= 1'b0;
      end else begin
         // Gap count: second bus reset with no write in between restores default
         if (gap_written) begin
            bus_reset_seen_r <= 1'b0;
         end else if (bus_reset_pulse) begin
            bus_reset_seen_r <= 1'b1;
         end
         if (bus_reset_pulse && !gap_written && bus_reset_seen_r) begin
            gap_count <= `PPRF_GAP_RESET;
         end else if (gap_cfg_valid) begin
            gap_count <= gap_cfg_value;
         end
         // Bus reset clears the long-reset request; link bit is untouched
         if (bus_reset_pulse) begin
            force_long_reset <= 1'b0;
         end
         if (reg_we && !paged_slot) begin
            case (cur_widx)
               `PPRF_IDX_RESET_GAP: begin
                  root_holdoff <= cur_wdata[7];
                  force_long_reset <= cur_wdata[6] && !bus_reset_pulse;
                  gap_count <= cur_wdata[5:0];
               end
               `PPRF_IDX_LINK_PWR: begin
                  // Jitter bits are fixed; only writable bits are stored
                  link_active_control <= cur_wdata[7];
                  contender_r <= cur_wdata[6];
                  pwr_class_r <= cur_wdata[2:0];
               end
               `PPRF_IDX_EVENT_EN: begin
                  event_enables <= cur_wdata;
               end
               `PPRF_IDX_PAGE_SEL: begin
                  page_select <= cur_wdata[7:5];
                  port_select <= cur_wdata[3:0];
               end
               default: begin
                  // Read-only and reserved base slots ignore writes
                  port_select <= port_select;
               end
            endcase
         end
      end
   end

   // Paged store: reserved pages never written
   wire page_we = reg_we && paged_slot && page_writable;
   wire [7:0] page_rdata;
   reg [3:0] rd_idx_r;
   wire [3:0] ar_idx = s_axi_araddr[5:2];

   pprf_page_mem #(
      .AW(6),
      .DW(8)
   ) u_page_mem (
      .clk(sys_clk),
      .rst_n(rst_sync_r),
      .wr_en(page_we),
      .wr_addr({page_select, cur_widx[2:0]}),
      .wr_data(cur_wdata),
      .rd_addr({page_select, ar_idx[2:0]}),
      .rd_data(page_rdata)
   );

   // ---------------------------------------------------------------
   // Read decode of the base map, independent of the page
   // ---------------------------------------------------------------
   reg [7:0] base_rd;
   always @* begin
      case (rd_idx_r)
         `PPRF_IDX_NODE_ID: base_rd = pos_byte(stat_r);
         `PPRF_IDX_RESET_GAP: base_rd = pos_byte({root_holdoff, force_long_reset, gap_count});
         `PPRF_IDX_PORT_CAP: base_rd = pos_byte({`PPRF_EXTENDED_VAL, `PPRF_NUM_PORTS_VAL});
         `PPRF_IDX_SPEED_CAP: base_rd = pos_byte({`PPRF_SPEED_VAL, 1'b0, `PPRF_DELAY_VAL});
         `PPRF_IDX_LINK_PWR: base_rd = pos_byte({link_active_control, contender_r,
                                                 `PPRF_JITTER_VAL, pwr_class_r});
         `PPRF_IDX_EVENT_EN: base_rd = event_enables;
         `PPRF_IDX_PAGE_SEL: base_rd = pos_byte({page_select, 1'b0, port_select});
         default: base_rd = 8'h00;
      endcase
   end

   // ---------------------------------------------------------------
   // AXI read channel: address taken, data two cycles later (memory latency, then response register)
   // ---------------------------------------------------------------
   reg rd_pend_r;
   reg rd_out_r;
   reg rd_stat_r;
   reg [2:0] rd_page_r;
   assign s_axi_arready = !rd_pend_r && !s_axi_rvalid && rst_sync_r;
   wire ar_take = s_axi_arvalid && s_axi_arready;
   wire rd_page_rsvd = (rd_page_r >= `PPRF_PAGE_RSVD_LO) && (rd_page_r <= `PPRF_PAGE_RSVD_HI);

   always @(posedge sys_clk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         rd_pend_r <= 1'b0;
         rd_out_r <= 1'b0;
         rd_stat_r <= 1'b0;
         rd_idx_r <= 4'h0;
         rd_page_r <= 3'h0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `PPRF_RESP_OKAY;
      end else begin
         if (ar_take) begin
            rd_pend_r <= 1'b1;
            rd_idx_r <= ar_idx;
            rd_page_r <= page_select;
            rd_stat_r <= (s_axi_araddr[31:2] == {25'h0, `PPRF_AXI_STATUS_IDX});
            rd_out_r <= (s_axi_araddr[31:6] != 26'h0);
         end
         if (rd_pend_r) begin
            rd_pend_r <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `PPRF_RESP_OKAY;
            if (rd_stat_r) begin
               // Bus-reset tracker, visible for diagnosis
               s_axi_rdata <= {31'h0, bus_reset_seen_r};
            end else if (rd_out_r) begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= `PPRF_RESP_SLVERR;
            end else if (rd_idx_r >= `PPRF_IDX_FIRST_PAGED) begin
               s_axi_rdata <= {24'h0, rd_page_rsvd ? 8'h00 : page_rdata};
            end else begin
               s_axi_rdata <= {24'h0, base_rd};
            end
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule

`default_nettype wire

// ==== include/pprf_defs.vh ====
/*
 Constants for the paged register file: register indices, field values, reset values,
 and the AXI4-Lite status word index and response codes. Assumes it is included by bare name in design files.
*/
`ifndef PPRF_DEFS_VH
`define PPRF_DEFS_VH

// ---------------------------------------------------------------
// Register indices (4-bit local address)
// ---------------------------------------------------------------
`define PPRF_IDX_NODE_ID 4'h0
`define PPRF_IDX_RESET_GAP 4'h1
`define PPRF_IDX_PORT_CAP 4'h2
`define PPRF_IDX_SPEED_CAP 4'h3
`define PPRF_IDX_LINK_PWR 4'h4
`define PPRF_IDX_EVENT_EN 4'h5
`define PPRF_IDX_RSVD_BASE 4'h6
`define PPRF_IDX_PAGE_SEL 4'h7
`define PPRF_IDX_FIRST_PAGED 4'h8

// ---------------------------------------------------------------
// Fixed capability fields, reset values and the reserved page range
// ---------------------------------------------------------------
`define PPRF_EXTENDED_VAL 3'h7
`define PPRF_NUM_PORTS_VAL 5'h01
`define PPRF_SPEED_VAL 3'h2
`define PPRF_DELAY_VAL 4'h0
`define PPRF_JITTER_VAL 3'h0
`define PPRF_GAP_RESET 6'h3f
`define PPRF_LINK_ACTIVE_CONTROL_RESET 1'b1
`define PPRF_PAGE_RSVD_LO 3'h2
`define PPRF_PAGE_RSVD_HI 3'h6

// ---------------------------------------------------------------
// AXI4-Lite map: register n at byte 4*n, window of 16 words,
// status/event port at word 16
// ---------------------------------------------------------------
`define PPRF_AXI_STATUS_IDX 5'h10
`define PPRF_RESP_OKAY 2'h0
`define PPRF_RESP_SLVERR 2'h2

`endif

// ==== verif/pprf_link_model.sv ====
/* Link-side register master: issues single reads and writes on AXI4-Lite.
   Assumes a slave on the same clock that answers in its own time. */
`timescale 1ns/100ps
`default_nettype none
module pprf_link_model (
   input wire logic sys_clk,
   output logic [31:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   output logic [31:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready
);
   // Idle bus at time zero
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
      s_axi_wstrb = 4'h0;
   end
   // Address and data offered together; each dropped, and scrambled, once taken
   task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic [3:0] s,
                     output logic [1:0] r);
      logic pa;
      logic pw;
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_wstrb <= s;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      {pa, pw} = 2'h3;
      do begin
         @(posedge sys_clk);
         if (s_axi_awready) pa = 1'b0;
         if (s_axi_wready) pw = 1'b0;
         s_axi_awvalid <= pa;
         s_axi_wvalid <= pw;
         if (!pa) s_axi_awaddr <= ~a;
         if (!pw) s_axi_wdata <= ~{24'h0, d};
      end while (pa | pw);
      do @(posedge sys_clk); while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   // Read: hold address until taken, hold ready until data comes
   task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge sys_clk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do @(posedge sys_clk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      s_axi_araddr <= ~a;
      do @(posedge sys_clk); while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ==== verif/pprf_props.sv ====
/* Checker for the paged register file, bound to its ports by name.
   Assumes one clock and the raw active-low reset pin. */
`timescale 1ns/100ps
`default_nettype none
module pprf_props (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic bus_reset_pulse,
   input wire logic gap_cfg_valid,
   input wire logic [5:0] gap_cfg_value,
   input wire logic [5:0] gap_count,
   input wire logic link_active_control,
   input wire logic [2:0] page_select
);
   // Raw pin disables; the design lags it by two flops, so reset values still show
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   sequence wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rd_reply;
      !s_axi_rvalid ##1 s_axi_rvalid;
   endsequence
   // Page field of the write data, kept as a plain signal for the history function
   logic [2:0] wr_page;
   assign wr_page = s_axi_wdata[7:5];
   a_reset_vals: assert property ($rose(rst_n) |-> gap_count == 6'h3f
      && link_active_control) else $error("gap count or link control wrong after reset");
   a_link_active_control_keep: assert property (bus_reset_pulse && !s_axi_awvalid
      |=> $stable(link_active_control)) else $error("link control moved on bus reset");
   a_gap_load: assert property (gap_cfg_valid && !bus_reset_pulse
      |=> gap_count == $past(gap_cfg_value)) else $error("gap count not loaded");
   a_wr_answer: assert property (wr_take |=> s_axi_bvalid)
      else $error("write response late");
   a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> rd_reply)
      else $error("read data not two cycles after address");
   a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
   a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("upper read bits not zero");
   a_page_write: assert property (wr_take ##0 s_axi_awaddr == 32'h1c
      |=> page_select == $past(wr_page)) else $error("page field not taken");
endmodule
bind pprf_regfile pprf_props u_props (.*);
`default_nettype wire

// ==== verif/tb_phy_paged_register_file.sv ====
/* Self-checking bench: link model on the register bus, core inputs driven here.
   Assumes the checker binds itself to the register file. */
`timescale 1ns/100ps
`default_nettype none
`include "pprf_defs.vh"
module tb_phy_paged_register_file;
   logic sys_clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic s_axi_rready, root_flag, cable_power_state, bus_reset_pulse, gap_cfg_valid;
   logic root_holdoff, force_long_reset, link_active_control;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rv;
   logic [5:0] node_number, gap_cfg_value, gap_count;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic [7:0] event_enables;
   logic [3:0] s_axi_wstrb, port_select;
   logic [2:0] page_select;
   int err_count, checks;
   pprf_regfile dut (.*);
   pprf_link_model link (.*);
   // 200 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rdc(input logic [31:0] a, input logic [7:0] e);
      link.rd(a, rv, rs);
      chk(rv, {24'h0, e});
      chk({30'h0, rs}, {30'h0, `PPRF_RESP_OKAY});
   endtask
   task automatic wrt(input logic [31:0] a, input logic [7:0] d);
      link.wr(a, d, 4'h1, rs);
   endtask
   task automatic bus_rst;
      @(posedge sys_clk);
      bus_reset_pulse <= 1'b1;
      @(posedge sys_clk);
      bus_reset_pulse <= 1'b0;
   endtask
   // Base map after reset; word 0 mirrors node 2a, root 1, cable power 0
   task automatic t_reset;
      logic [7:0] e [8] = '{8'haa, 8'h3f, 8'he1, 8'h40, 8'h80, 8'h00, 8'h00, 8'h00};
      chk({26'h0, gap_count}, 32'h3f);
      chk({31'h0, link_active_control}, 32'h1);
      for (int i = 0; i < 8; i++)
         rdc(32'(4 * i), e[i]);
   endtask
   // Every page chosen in turn, page must be set before paged words are used
   task automatic t_page;
      for (int p = 0; p < 8; p++) begin
         wrt(32'h1c, {p[2:0], 5'h15});
         chk({29'h0, page_select}, 32'(p));
         chk({28'h0, port_select}, 32'h5);
         rdc(32'h1c, {p[2:0], 5'h05});
         wrt(32'(32 + 4 * p), 8'h30 + p[7:0]);
      end
      for (int p = 0; p < 8; p++) begin
         wrt(32'h1c, {p[2:0], 5'h00});
         rdc(32'h08, 8'he1);
         rdc(32'(32 + 4 * p), (p > 1 && p < 7) ? 8'h00 : 8'h30 + p[7:0]);
      end
   endtask
   // Read-only, reserved, unmapped and strobe-less writes
   task automatic t_ro;
      wrt(32'h08, 8'h00);
      wrt(32'h0c, 8'hff);
      wrt(32'h18, 8'hff);
      rdc(32'h08, 8'he1);
      rdc(32'h0c, 8'h40);
      rdc(32'h18, 8'h00);
      wrt(32'h10, 8'h7f);
      rdc(32'h10, 8'h47);
      chk({31'h0, link_active_control}, 32'h0);
      link.wr(32'h44, 8'h01, 4'h1, rs);
      chk({30'h0, rs}, {30'h0, `PPRF_RESP_SLVERR});
      link.wr(32'h40, 8'h01, 4'h1, rs);
      chk({30'h0, rs}, {30'h0, `PPRF_RESP_SLVERR});
      link.rd(32'h44, rv, rs);
      chk(rv, 32'h0);
      chk({30'h0, rs}, {30'h0, `PPRF_RESP_SLVERR});
      link.wr(32'h14, 8'hff, 4'h0, rs);
      chk({30'h0, rs}, {30'h0, `PPRF_RESP_OKAY});
      rdc(32'h14, 8'h00);
      wrt(32'h14, 8'h81);
      chk({24'h0, event_enables}, 32'h81);
   endtask
   // Gap count survives one bus reset, returns to 3f on the second
   task automatic t_gap;
      wrt(32'h04, 8'hc5);
      chk({24'h0, gap_count, root_holdoff, force_long_reset}, 32'h17);
      rdc(32'h40, 8'h00);
      bus_rst;
      rdc(32'h04, 8'h85);
      rdc(32'h40, 8'h01);
      chk({31'h0, link_active_control}, 32'h0);
      bus_rst;
      rdc(32'h04, 8'hbf);
      @(posedge sys_clk);
      gap_cfg_value <= 6'h0a;
      gap_cfg_valid <= 1'b1;
      @(posedge sys_clk);
      gap_cfg_valid <= 1'b0;
      bus_rst;
      rdc(32'h04, 8'h8a);
   endtask
   // Hardware reset in mid-run: link bit was cleared, paged word was written
   task automatic t_rerst;
      @(posedge sys_clk);
      rst_n <= 1'b0;
      repeat (6) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      chk({26'h0, gap_count}, 32'h3f);
      chk({31'h0, link_active_control}, 32'h1);
      rdc(32'h10, 8'h80);
      rdc(32'h1c, 8'h00);
      rdc(32'h20, 8'h00);
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Main sequence; ready rises two edges after release
   initial begin
      {rst_n, root_flag, cable_power_state, bus_reset_pulse, gap_cfg_valid} = 5'h08;
      {node_number, gap_cfg_value} = 12'ha80;
      {err_count, checks} = 64'h0;
      repeat (6) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      t_reset;
      t_page;
      t_ro;
      t_gap;
      t_rerst;
      results;
   end
   // The run needs well under a thousand cycles; four thousand means a hang
   initial begin
      #20000;
      err_count++;
      results;
   end
endmodule
`default_nettype wire
